// [rtl/dwc_diag_watchdog_regs.sv]
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dwc_diag_watchdog_regs #(
    parameter int US_PRESCALE = dwc_pkg::CYCLES_PER_US
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [dwc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [dwc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [dwc_pkg::DATA_W-1:0] rdata_o,
    // stored non-volatile copies
    input wire logic [3:0] stored_diag_current_i,
    input wire logic [3:0] stored_diag_pulse_width_i,
    input wire logic [3:0] stored_watchdog_select_i,
    // on-demand diagnostics
    input wire logic diag_start_i,
    output logic diag_pulse_o,
    output logic diag_done_o,
    output logic [5:0] diag_current_num_o,
    output logic diag_use_channel_current_o,
    output logic [dwc_pkg::PW_US_W-1:0] diag_pulse_width_us_o,
    // watchdog
    input wire logic wdt_kick_i,
    input wire logic failsafe_clear_i,
    output logic failsafe_o,
    output logic wdt_enabled_o,
    output logic [dwc_pkg::US_W-1:0] wdt_timeout_us_o
);
    import dwc_pkg::*;

    typedef enum logic [1:0] {
        DIAG_IDLE = 2'b01,
        DIAG_PULSE = 2'b10
    } dwc_diag_state_t;

    typedef enum logic [2:0] {
        WDT_OFF = 3'b001,
        WDT_ARMED = 3'b010,
        WDT_TRIPPED = 3'b100
    } dwc_wdt_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode, shared by the write strobes and the read mux

    function automatic logic [1:0] reg_hit(input logic [ADDR_W-1:0] addr);
        reg_hit = 2'b00;
        if (addr == DIAG_CFG_OFFSET)
            reg_hit = 2'b01;
        else if (addr == WDT_CFG_OFFSET)
            reg_hit = 2'b10;
    endfunction

    logic [1:0] hit;

    assign hit = reg_hit(addr_i);

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [3:0] diag_current_code_reg;
    logic [3:0] diag_pulse_width_code_reg;
    logic [3:0] watchdog_timeout_select_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic wr_diag;
    logic wr_wdt;

    assign wr_diag = wr_i && hit[0];
    assign wr_wdt = wr_i && hit[1];

    // reset is synchronous, so loading the stored copies here is a clocked capture
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            diag_current_code_reg <= stored_diag_current_i;
            diag_pulse_width_code_reg <= stored_diag_pulse_width_i;
        end
        else if (wr_diag)
        begin
            diag_current_code_reg <= wdata_i[CODE_HI:CODE_LO];
            diag_pulse_width_code_reg <= wdata_i[CODE_LO-1:0];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            watchdog_timeout_select_reg <= stored_watchdog_select_i;
        else if (wr_wdt)
            watchdog_timeout_select_reg <= wdata_i[CODE_HI:CODE_LO]; // low bits dropped
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    // idle data held at zero so a stale read never looks fresh

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            rdata_reg <= '0;
        else if (rd_i)
        begin
            case (hit)
                2'b01:
                    rdata_reg <= {diag_current_code_reg, diag_pulse_width_code_reg};
                2'b10:
                    rdata_reg <= {watchdog_timeout_select_reg, RESERVED_READ};
                default:
                    rdata_reg <= '0;
            endcase
        end
        else
            rdata_reg <= '0;
    end

    assign rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // diagnostic current and width decode

    logic [5:0] current_num_reg;
    logic use_channel_reg;
    logic [PW_US_W-1:0] pulse_width_us_reg;

    // decode lags the code register by one cycle so the outputs stay plain flops
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            current_num_reg <= '0;
            use_channel_reg <= 1'b0;
        end
        else if (diag_current_code_reg == CURRENT_CHANNEL_CODE)
        begin
            // numerator held at full scale so a reader never sees a stale fraction
            current_num_reg <= CURRENT_DENOM;
            use_channel_reg <= 1'b1;
        end
        else
        begin
            current_num_reg <= {diag_current_code_reg, 2'b01}; // code*4+1 of 64
            use_channel_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            pulse_width_us_reg <= '0;
        else
            pulse_width_us_reg <= pulse_us(diag_pulse_width_code_reg);
    end

    assign diag_current_num_o = current_num_reg;
    assign diag_use_channel_current_o = use_channel_reg;
    assign diag_pulse_width_us_o = pulse_width_us_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // on-demand diagnostic pulse

    dwc_timer_if diag_tmr ();
    dwc_diag_state_t diag_state_reg;
    logic diag_start_reg;
    logic diag_done_reg;

    dwc_interval_timer #(
        .PRESCALE(US_PRESCALE)
    ) u_diag_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tmr(diag_tmr.timer)
    );

    // width is read straight from the code so a start right after a write uses it
    assign diag_tmr.start = diag_start_reg;
    assign diag_tmr.duration_us = US_W'(pulse_us(diag_pulse_width_code_reg));

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            diag_state_reg <= DIAG_IDLE;
            diag_start_reg <= 1'b0;
            diag_done_reg <= 1'b0;
        end
        else
        begin
            diag_start_reg <= 1'b0;
            diag_done_reg <= 1'b0;
            case (diag_state_reg)
                DIAG_IDLE:
                    if (diag_start_i)
                    begin
                        diag_start_reg <= 1'b1;
                        diag_state_reg <= DIAG_PULSE;
                    end
                DIAG_PULSE:
                    if (diag_tmr.expired)
                    begin
                        diag_done_reg <= 1'b1;
                        diag_state_reg <= DIAG_IDLE;
                    end
                default:
                    diag_state_reg <= DIAG_IDLE;
            endcase
        end
    end

    // starts during a running pulse are ignored, not queued
    assign diag_pulse_o = (diag_state_reg == DIAG_PULSE);
    assign diag_done_o = diag_done_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog

    dwc_timer_if wdt_tmr ();
    dwc_wdt_state_t wdt_state_reg;
    logic wdt_restart_reg;
    logic failsafe_reg;
    logic [US_W-1:0] wdt_timeout_reg;
    logic wdt_disabled;
    logic wdt_immediate;
    logic wdt_trip;

    assign wdt_disabled = (watchdog_timeout_select_reg == WDT_DISABLED_CODE);
    assign wdt_immediate = (watchdog_timeout_select_reg >= WDT_IMMEDIATE_CODE);
    // a pending restart masks an expiry left over from the old wait
    assign wdt_trip = (wdt_state_reg == WDT_ARMED) && wdt_tmr.expired && !wdt_restart_reg;

    dwc_interval_timer #(
        .PRESCALE(US_PRESCALE)
    ) u_wdt_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tmr(wdt_tmr.timer)
    );

    assign wdt_tmr.start = wdt_restart_reg;
    assign wdt_tmr.duration_us = wdt_us(watchdog_timeout_select_reg);

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            wdt_timeout_reg <= '0;
        else
            wdt_timeout_reg <= wdt_us(watchdog_timeout_select_reg);
    end

    // a kick, or a new selection, restarts the wait from zero unless the wait expires in that same cycle
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            wdt_state_reg <= WDT_OFF;
            wdt_restart_reg <= 1'b0;
        end
        else
        begin
            wdt_restart_reg <= 1'b0;
            case (wdt_state_reg)
                WDT_OFF:
                    if (!wdt_disabled && !wdt_immediate)
                    begin
                        wdt_restart_reg <= 1'b1;
                        wdt_state_reg <= WDT_ARMED;
                    end
                WDT_ARMED:
                    if (wdt_disabled || wdt_immediate)
                        wdt_state_reg <= WDT_OFF;
                    else if (wdt_trip)
                        wdt_state_reg <= WDT_TRIPPED;
                    else if (wdt_kick_i || wr_wdt)
                        wdt_restart_reg <= 1'b1;
                WDT_TRIPPED:
                    if (failsafe_clear_i || wdt_disabled || wdt_immediate)
                        wdt_state_reg <= WDT_OFF;
                default:
                    wdt_state_reg <= WDT_OFF;
            endcase
        end
    end

    // a new trip in the clear cycle wins over the clear
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            failsafe_reg <= 1'b0;
        else if (wdt_immediate)
            failsafe_reg <= 1'b1;
        else if (wdt_trip)
            failsafe_reg <= 1'b1;
        else if (failsafe_clear_i || wdt_disabled)
            failsafe_reg <= 1'b0;
    end

    assign failsafe_o = failsafe_reg;
    assign wdt_enabled_o = !wdt_disabled;
    assign wdt_timeout_us_o = wdt_timeout_reg;

endmodule // dwc_diag_watchdog_regs
`default_nettype wire

// [rtl/dwc_pkg.sv]
// Function
// - an 8-bit read-write on-demand diagnostics register sits at offset 0x59 and resets from stored settings.
// - bits 7 to 4 of that register hold the diagnostic output current code.
// - current codes 0x0 to 0xE give (code*4+1)/64 of the full-range reference current.
// - current code 0xF makes each channel use its own configured output current.
// - every reset loads the current code from its stored non-volatile copy.
// - bits 3 to 0 select the diagnostic pulse width from 20 us up to 5 ms by the fixed table.
// - every reset loads the pulse-width code from its stored non-volatile copy.
// - an 8-bit watchdog register at offset 0x5a holds the timeout select in bits 7 to 4 and resets from stored settings.
// - select 0 disables fail-safe entry, 1 to 0xb give 200 us to 500 ms, 0xc and above enter fail-safe at once.
package dwc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int CLOCK_HZ = 40_000_000;
    localparam int US_PER_S = 1_000_000;
    localparam int CYCLES_PER_US = CLOCK_HZ / US_PER_S;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int US_W = 19;
    localparam int PW_US_W = 13;

    localparam logic [7:0] DIAG_CFG_OFFSET = 8'h59;
    localparam logic [7:0] WDT_CFG_OFFSET = 8'h5a;

    localparam int CODE_HI = 7;
    localparam int CODE_LO = 4;
    localparam logic [3:0] CURRENT_CHANNEL_CODE = 4'hf;
    localparam logic [5:0] CURRENT_DENOM = 6'h3f; // full-scale numerator 63, denominator is 64
    localparam logic [3:0] WDT_DISABLED_CODE = 4'h0;
    localparam logic [3:0] WDT_IMMEDIATE_CODE = 4'hc;
    localparam logic [3:0] RESERVED_READ = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // pulse width in microseconds
    function automatic logic [PW_US_W-1:0] pulse_us(input logic [3:0] code);
        case (code)
            4'h0: pulse_us = 13'd100;
            4'h1: pulse_us = 13'd20;
            4'h2: pulse_us = 13'd30;
            4'h3: pulse_us = 13'd50;
            4'h4: pulse_us = 13'd80;
            4'h5: pulse_us = 13'd150;
            4'h6: pulse_us = 13'd200;
            4'h7: pulse_us = 13'd300;
            4'h8: pulse_us = 13'd500;
            4'h9: pulse_us = 13'd800;
            4'ha: pulse_us = 13'd1000;
            4'hb: pulse_us = 13'd1200;
            4'hc: pulse_us = 13'd1500;
            4'hd: pulse_us = 13'd2000;
            4'he: pulse_us = 13'd3000;
            default: pulse_us = 13'd5000;
        endcase
    endfunction

    // watchdog timeout in microseconds, zero where no timed wait applies
    function automatic logic [US_W-1:0] wdt_us(input logic [3:0] code);
        case (code)
            4'h1: wdt_us = 19'd200;
            4'h2: wdt_us = 19'd500;
            4'h3: wdt_us = 19'd1000;
            4'h4: wdt_us = 19'd2000;
            4'h5: wdt_us = 19'd5000;
            4'h6: wdt_us = 19'd10000;
            4'h7: wdt_us = 19'd20000;
            4'h8: wdt_us = 19'd50000;
            4'h9: wdt_us = 19'd100000;
            4'ha: wdt_us = 19'd200000;
            4'hb: wdt_us = 19'd500000;
            default: wdt_us = 19'd0;
        endcase
    endfunction

endpackage

// [rtl/dwc_timer_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dwc_timer_if;
    import dwc_pkg::*;
    logic start;
    logic [US_W-1:0] duration_us;
    logic busy;
    logic expired;
    modport ctrl (output start, output duration_us, input busy, input expired);
    modport timer (input start, input duration_us, output busy, output expired);
endinterface // dwc_timer_if
`default_nettype wire

// [rtl/dwc_interval_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module dwc_interval_timer #(
    parameter int PRESCALE = dwc_pkg::CYCLES_PER_US
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // control
    dwc_timer_if.timer tmr
);
    import dwc_pkg::*;

    logic [15:0] pre_reg;
    logic [US_W-1:0] left_reg;
    logic busy_reg;
    logic expired_reg;
    logic tick;

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler restarts with each start so the first microsecond is whole
    assign tick = (pre_reg == 16'(PRESCALE - 1));

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i || tmr.start || tick)
            pre_reg <= 16'h0000;
        else if (busy_reg)
            pre_reg <= pre_reg + 16'h0001;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            left_reg <= '0;
            busy_reg <= 1'b0;
            expired_reg <= 1'b0;
        end
        else if (tmr.start)
        begin
            left_reg <= tmr.duration_us;
            busy_reg <= (tmr.duration_us != '0);
            expired_reg <= (tmr.duration_us == '0);
        end
        else
        begin
            expired_reg <= 1'b0;
            if (busy_reg && tick)
            begin
                left_reg <= left_reg - US_W'(1);
                if (left_reg == US_W'(1))
                begin
                    busy_reg <= 1'b0;
                    expired_reg <= 1'b1;
                end
            end
        end
    end

    assign tmr.busy = busy_reg;
    assign tmr.expired = expired_reg;

endmodule // dwc_interval_timer
`default_nettype wire

// [testbench/dwc_diag_watchdog_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module dwc_diag_watchdog_regs_props #(
    parameter int US_PRESCALE = dwc_pkg::CYCLES_PER_US
) (
    // clock, reset and register port
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [dwc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [dwc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [dwc_pkg::DATA_W-1:0] rdata_o,
    // stored copies
    input wire logic [3:0] stored_diag_current_i,
    input wire logic [3:0] stored_diag_pulse_width_i,
    input wire logic [3:0] stored_watchdog_select_i,
    // diagnostics and watchdog
    input wire logic diag_start_i,
    input wire logic diag_pulse_o,
    input wire logic diag_done_o,
    input wire logic [5:0] diag_current_num_o,
    input wire logic diag_use_channel_current_o,
    input wire logic [dwc_pkg::PW_US_W-1:0] diag_pulse_width_us_o,
    input wire logic wdt_kick_i,
    input wire logic failsafe_clear_i,
    input wire logic failsafe_o,
    input wire logic wdt_enabled_o,
    input wire logic [dwc_pkg::US_W-1:0] wdt_timeout_us_o
);
    import dwc_pkg::*;
    ////////////////////////////////////////////////////////////
    wire w59 = wr_i && addr_i == DIAG_CFG_OFFSET;
    wire w5a = wr_i && addr_i == WDT_CFG_OFFSET;
    wire r59 = rd_i && addr_i == DIAG_CFG_OFFSET;
    wire r5a = rd_i && addr_i == WDT_CFG_OFFSET;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////
    a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    a_diag_readback: assert property (w59 ##1 r59 |=> rdata_o == $past(wdata_i, 2))
        else $error("diag register readback wrong");
    a_wdt_readback: assert property (w5a ##1 r5a |=> rdata_o[7:4] == $past(wdata_i[7:4], 2))
        else $error("watchdog select readback wrong");
    a_wdt_low_zero: assert property (r5a |=> rdata_o[3:0] == RESERVED_READ)
        else $error("reserved watchdog bits not zero");
    // reset must not disable these: they watch the load itself
    a_reset_load_diag: assert property (disable iff (1'b0) !rst_n_i ##1 rst_n_i && r59 |=>
        rdata_o == {$past(stored_diag_current_i, 2), $past(stored_diag_pulse_width_i, 2)})
        else $error("diag register not loaded at reset");
    a_reset_load_wdt: assert property (disable iff (1'b0) !rst_n_i ##1 rst_n_i |->
        wdt_enabled_o == ($past(stored_watchdog_select_i) != 4'h0))
        else $error("watchdog select not loaded at reset");
    a_current_scale: assert property (w59 && wdata_i[7:4] != 4'hf ##1 !wr_i |=>
        diag_current_num_o == {$past(wdata_i[7:4], 2), 2'b01})
        else $error("diag current numerator wrong");
    a_channel_flag: assert property (w59 ##1 !wr_i |=>
        diag_use_channel_current_o == ($past(wdata_i[7:4], 2) == CURRENT_CHANNEL_CODE))
        else $error("channel current flag wrong");
    a_failsafe_now: assert property (w5a && wdata_i[7:4] >= WDT_IMMEDIATE_CODE |-> ##[1:3] failsafe_o)
        else $error("immediate fail-safe missing");
    a_wdt_off: assert property (w5a && wdata_i[7:4] == WDT_DISABLED_CODE |=> !wdt_enabled_o)
        else $error("watchdog still enabled");
    a_diag_start: assert property (diag_start_i && !diag_pulse_o |=> diag_pulse_o)
        else $error("diag pulse did not start");
    a_done_ends_pulse: assert property ($rose(diag_done_o) |-> !diag_pulse_o && $past(diag_pulse_o))
        else $error("done without a running pulse");
    c_trip: cover property ($rose(failsafe_o));
    c_done: cover property (diag_done_o);
    c_read: cover property (r59 ##1 rdata_o != 8'h00);
endmodule // dwc_diag_watchdog_regs_props
`default_nettype wire

// [testbench/dwc_diag_watchdog_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module dwc_diag_watchdog_regs_test;
    import dwc_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] st_cur = 4'h0;
    logic [3:0] st_pw = 4'h0;
    logic [3:0] st_sel = 4'h0;
    logic start = 1'b0;
    logic kick = 1'b0;
    logic clr = 1'b0;
    logic [7:0] rdata_o;
    logic pulse, done, use_ch, failsafe_o, wdt_en;
    logic [5:0] num;
    logic [12:0] pw_us;
    logic [18:0] wdt_us;
    int bad_count = 0;
    int n_compared = 0;
    int n;
    logic [18:0] pw_tab [16] = '{19'h64, 19'h14, 19'h1e, 19'h32, 19'h50, 19'h96, 19'hc8, 19'h12c,
        19'h1f4, 19'h320, 19'h3e8, 19'h4b0, 19'h5dc, 19'h7d0, 19'hbb8, 19'h1388};
    logic [18:0] wd_tab [16] = '{19'h0, 19'hc8, 19'h1f4, 19'h3e8, 19'h7d0, 19'h1388, 19'h2710,
        19'h4e20, 19'hc350, 19'h186a0, 19'h30d40, 19'h7a120, 19'h0, 19'h0, 19'h0, 19'h0};
    always #12.5 clock_i = ~clock_i;
    // small prescale keeps the 200 us watchdog wait at 400 cycles
    dwc_diag_watchdog_regs #(.US_PRESCALE(2)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .stored_diag_current_i(st_cur), .stored_diag_pulse_width_i(st_pw),
        .stored_watchdog_select_i(st_sel), .diag_start_i(start), .diag_pulse_o(pulse),
        .diag_done_o(done), .diag_current_num_o(num), .diag_use_channel_current_o(use_ch),
        .diag_pulse_width_us_o(pw_us), .wdt_kick_i(kick), .failsafe_clear_i(clr),
        .failsafe_o(failsafe_o), .wdt_enabled_o(wdt_en), .wdt_timeout_us_o(wdt_us));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [18:0] seen, input logic [18:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1;
        chk("read data", {11'h0, rdata_o}, {11'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask
    task automatic do_reset(input logic [3:0] c, input logic [3:0] p, input logic [3:0] s);
        @(posedge clock_i);
        st_cur <= c;
        st_pw <= p;
        st_sel <= s;
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd_i <= 1'b1;
        addr_i <= DIAG_CFG_OFFSET;
        bus(1'b0, 1'b0, DIAG_CFG_OFFSET, 8'h00);
        #1;
        chk("reset load", {11'h0, rdata_o}, {11'h0, c, p});
        st_cur <= ~c;
        rd_chk(WDT_CFG_OFFSET, {s, 4'h0});
        rd_chk(DIAG_CFG_OFFSET, {c, p});
        $display("reset test done");
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_codes();
        logic [3:0] c;
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            bus(1'b1, 1'b0, DIAG_CFG_OFFSET, {c, c});
            rd_chk(DIAG_CFG_OFFSET, {c, c});
            if (c != 4'hf)
                chk("current", {13'h0, num}, {13'h0, c, 2'b01});
            else
                chk("current full", {13'h0, num}, 19'h3f);
            chk("channel flag", {18'h0, use_ch}, {18'h0, c == 4'hf});
            chk("width", {6'h0, pw_us}, pw_tab[i]);
            bus(1'b1, 1'b0, WDT_CFG_OFFSET, {c, 4'hf});
            rd_chk(WDT_CFG_OFFSET, {c, 4'h0});
            chk("wdt enabled", {18'h0, wdt_en}, {18'h0, c != 4'h0});
            chk("wdt timeout", wdt_us, wd_tab[i]);
            chk("failsafe", {18'h0, failsafe_o}, {18'h0, c >= 4'hc});
        end
        wr(8'h58, 8'hff);
        rd_chk(8'h58, 8'h00);
        $display("code test done");
    endtask
    task automatic t_pulse();
        wr(DIAG_CFG_OFFSET, 8'h01);
        @(posedge clock_i);
        start <= 1'b1;
        @(posedge clock_i);
        // second start lands while running and must not restart it
        @(posedge clock_i);
        start <= 1'b0;
        #1;
        chk("pulse running", {18'h0, pulse}, 19'h1);
        for (n = 1; n < 200 && done !== 1'b1; n++)
        begin
            @(posedge clock_i);
            #1;
        end
        chk("pulse length", {18'h0, n >= 40 && n <= 42}, 19'h1);
        chk("pulse ended", {18'h0, pulse}, 19'h0);
        if (n >= 200)
            end_sim();
        $display("pulse test done");
    endtask
    task automatic t_wdt();
        wr(WDT_CFG_OFFSET, 8'h00);
        wr(WDT_CFG_OFFSET, 8'h10);
        repeat (300) @(posedge clock_i);
        kick <= 1'b1;
        @(posedge clock_i);
        kick <= 1'b0;
        #1;
        for (n = 0; n < 1000 && failsafe_o !== 1'b1; n++)
        begin
            @(posedge clock_i);
            #1;
        end
        chk("trip time", {18'h0, n >= 398 && n <= 410}, 19'h1);
        if (n >= 1000)
            end_sim();
        @(posedge clock_i);
        clr <= 1'b1;
        @(posedge clock_i);
        clr <= 1'b0;
        @(posedge clock_i);
        #1;
        chk("cleared", {18'h0, failsafe_o}, 19'h0);
        $display("watchdog test done");
    endtask
    initial
    begin
        do_reset(4'h3, 4'ha, 4'h2);
        t_codes();
        t_pulse();
        t_wdt();
        do_reset(4'hf, 4'h5, 4'hc);
        chk("reset failsafe", {18'h0, failsafe_o}, 19'h1);
        chk("reset channel", {18'h0, use_ch}, 19'h1);
        end_sim();
    end
endmodule // dwc_diag_watchdog_regs_test
bind dwc_diag_watchdog_regs dwc_diag_watchdog_regs_props #(.US_PRESCALE(US_PRESCALE)) u_props (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .stored_diag_current_i(stored_diag_current_i),
    .stored_diag_pulse_width_i(stored_diag_pulse_width_i),
    .stored_watchdog_select_i(stored_watchdog_select_i), .diag_start_i(diag_start_i),
    .diag_pulse_o(diag_pulse_o), .diag_done_o(diag_done_o),
    .diag_current_num_o(diag_current_num_o),
    .diag_use_channel_current_o(diag_use_channel_current_o),
    .diag_pulse_width_us_o(diag_pulse_width_us_o), .wdt_kick_i(wdt_kick_i),
    .failsafe_clear_i(failsafe_clear_i), .failsafe_o(failsafe_o),
    .wdt_enabled_o(wdt_enabled_o), .wdt_timeout_us_o(wdt_timeout_us_o));
`default_nettype wire
